/* design/tmw_tick_gen.sv */
`timescale 1ns/1ns
`include "tmw_defines.svh"
module tmw_tick_gen (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [2:0] clk_source_sel,
	input wire logic ext_count_in,
	output logic tick
);
	logic [9:0] pre_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic [9:0] div_lim;
	logic tick_d;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pre_q <= 10'h000;
		end else begin
			pre_q <= pre_q + 10'h001;
		end
	end

	// The pin is sampled regardless of its direction, so software can drive counting.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_count_in; // R17
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	always_comb begin
		div_lim = `TMW_DIV_8;
		tick_d = 1'b0;
		case (tmw_pkg::tmw_clk_sel_t'(clk_source_sel))
			tmw_pkg::TMW_CS_STOP: tick_d = 1'b0; // R15
			tmw_pkg::TMW_CS_DIV1: tick_d = 1'b1; // R15
			tmw_pkg::TMW_CS_DIV8: div_lim = `TMW_DIV_8; // R16
			tmw_pkg::TMW_CS_DIV64: div_lim = `TMW_DIV_64; // R16
			tmw_pkg::TMW_CS_DIV256: div_lim = `TMW_DIV_256; // R16
			tmw_pkg::TMW_CS_DIV1024: div_lim = `TMW_DIV_1024; // R16
			tmw_pkg::TMW_CS_EXT_FALL: tick_d = ext_s3_q & ~ext_s2_q; // R16
			tmw_pkg::TMW_CS_EXT_RISE: tick_d = ext_s2_q & ~ext_s3_q; // R16
			default: tick_d = 1'b0;
		endcase
		if (clk_source_sel >= 3'h2 && clk_source_sel <= 3'h5) begin
			tick_d = ((pre_q & div_lim) == div_lim);
		end
	end

	assign tick = tick_d;
endmodule

/* design/tmw_timer.sv */
`timescale 1ns/1ns
`include "tmw_defines.svh"
module tmw_timer (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	input wire logic ext_count_in,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic wave_en_a_q,
	output logic wave_en_b_q,
	output logic overflow_pulse_q,
	output logic match_a_pulse_q,
	output logic match_b_pulse_q
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] ctrl_a_q;
	logic [7:0] ctrl_b_q;
	logic [7:0] count_q;
	logic [7:0] cmp_a_q;
	logic [7:0] cmp_b_q;
	logic [7:0] cmp_a_buf_q;
	logic [7:0] cmp_b_buf_q;
	logic down_q;
	logic block_q;
	logic force_a_q;
	logic force_b_q;
	logic tick;
	logic [2:0] wave_gen_mode;
	logic [1:0] out_mode_a;
	logic [1:0] out_mode_b;
	logic [1:0] wave_sel;
	logic [7:0] top_val;
	logic at_top;
	logic at_bottom;
	logic match_a;
	logic match_b;
	logic wr_a;
	logic wr_b;
	logic wr_cnt;
	logic wr_ca;
	logic wr_cb;
	logic top_from_a;
	logic [7:0] count_d;
	logic down_d;

	assign wr_a = reg_wr && reg_addr == `TMW_OFS_CTRL_A;
	assign wr_b = reg_wr && reg_addr == `TMW_OFS_CTRL_B;
	assign wr_cnt = reg_wr && reg_addr == `TMW_OFS_COUNT;
	assign wr_ca = reg_wr && reg_addr == `TMW_OFS_CMP_A;
	assign wr_cb = reg_wr && reg_addr == `TMW_OFS_CMP_B;

	// ----------------------------------------------------------------
	// Mode decoding
	// ----------------------------------------------------------------
	assign wave_gen_mode = {ctrl_b_q[`TMW_BIT_WGM_HI], ctrl_a_q[1:0]}; // R07
	assign out_mode_a = ctrl_a_q[7:6];
	assign out_mode_b = ctrl_a_q[5:4];

	always_comb begin
		wave_sel = tmw_pkg::TMW_NON_PWM;
		top_from_a = 1'b0;
		case (wave_gen_mode) // R08
			3'd1: wave_sel = tmw_pkg::TMW_PHASE_PWM;
			3'd2: top_from_a = 1'b1;
			3'd3: wave_sel = tmw_pkg::TMW_FAST_PWM;
			3'd5: begin
				wave_sel = tmw_pkg::TMW_PHASE_PWM;
				top_from_a = 1'b1;
			end
			3'd7: begin
				wave_sel = tmw_pkg::TMW_FAST_PWM;
				top_from_a = 1'b1;
			end
			default: wave_sel = tmw_pkg::TMW_NON_PWM; // R21
		endcase
		top_val = top_from_a ? cmp_a_q : `TMW_MAX;
	end

	assign at_top = count_q == top_val;
	assign at_bottom = count_q == `TMW_BOTTOM;
	assign match_a = tick && !block_q && count_q == cmp_a_q; // R18
	assign match_b = tick && !block_q && count_q == cmp_b_q; // R18

	// ----------------------------------------------------------------
	// Clock source
	// ----------------------------------------------------------------
	tmw_tick_gen u_tick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_source_sel(ctrl_b_q[2:0]),
		.ext_count_in(ext_count_in),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_a_q <= `TMW_RST_BYTE;
			ctrl_b_q <= `TMW_RST_BYTE;
		end else begin
			if (wr_a) ctrl_a_q <= reg_wdata & `TMW_CTRL_A_MASK;
			if (wr_b) ctrl_b_q <= reg_wdata & `TMW_CTRL_B_MASK; // R14
		end
	end

	// Force bits are only latched for one cycle and ignored in PWM modes.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			force_a_q <= 1'b0;
			force_b_q <= 1'b0;
		end else begin
			force_a_q <= wr_b && reg_wdata[`TMW_BIT_FORCE_A]
				&& wave_sel == tmw_pkg::TMW_NON_PWM; // R10 R11
			force_b_q <= wr_b && reg_wdata[`TMW_BIT_FORCE_B]
				&& wave_sel == tmw_pkg::TMW_NON_PWM; // R10
		end
	end

	// Buffered compare values load immediately in non-PWM modes and at TOP in both PWM modes.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmp_a_buf_q <= `TMW_RST_BYTE;
			cmp_b_buf_q <= `TMW_RST_BYTE;
			cmp_a_q <= `TMW_RST_BYTE;
			cmp_b_q <= `TMW_RST_BYTE;
		end else begin
			if (wr_ca) cmp_a_buf_q <= reg_wdata;
			if (wr_cb) cmp_b_buf_q <= reg_wdata;
			if (wave_sel == tmw_pkg::TMW_NON_PWM) begin // R09
				cmp_a_q <= wr_ca ? reg_wdata : cmp_a_buf_q;
				cmp_b_q <= wr_cb ? reg_wdata : cmp_b_buf_q;
			end else if (tick && ((wave_sel == tmw_pkg::TMW_PHASE_PWM && at_top)
				|| (wave_sel == tmw_pkg::TMW_FAST_PWM && at_top))) begin // R09
				cmp_a_q <= cmp_a_buf_q;
				cmp_b_q <= cmp_b_buf_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_comb begin
		count_d = count_q;
		down_d = down_q;
		if (tick) begin
			if (wave_sel == tmw_pkg::TMW_PHASE_PWM) begin // R20
				if (!down_q && at_top) begin
					down_d = 1'b1;
					count_d = count_q - 8'h01;
				end else if (down_q && at_bottom) begin
					down_d = 1'b0;
					count_d = count_q + 8'h01;
				end else begin
					count_d = down_q ? count_q - 8'h01 : count_q + 8'h01;
				end
			end else begin
				down_d = 1'b0;
				// A forced match never clears the counter; only real TOP does.
				count_d = at_top ? `TMW_BOTTOM : count_q + 8'h01; // R13 R20
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_q <= `TMW_RST_BYTE;
			down_q <= 1'b0;
			block_q <= 1'b0;
		end else begin
			count_q <= wr_cnt ? reg_wdata : count_d;
			down_q <= down_d;
			if (wr_cnt) block_q <= 1'b1; // R18
			else if (tick) block_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Events and readback
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			overflow_pulse_q <= 1'b0;
			match_a_pulse_q <= 1'b0;
			match_b_pulse_q <= 1'b0;
		end else begin
			case (wave_gen_mode) // R09
				3'd1, 3'd5: overflow_pulse_q <= tick && down_q && at_bottom;
				3'd7: overflow_pulse_q <= tick && at_top;
				default: overflow_pulse_q <= tick && count_q == `TMW_MAX;
			endcase
			match_a_pulse_q <= match_a; // R13
			match_b_pulse_q <= match_b; // R13
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata_q <= `TMW_RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				`TMW_OFS_CTRL_A: reg_rdata_q <= ctrl_a_q;
				`TMW_OFS_CTRL_B: reg_rdata_q <= ctrl_b_q; // R14
				`TMW_OFS_COUNT: reg_rdata_q <= count_q;
				`TMW_OFS_CMP_A: reg_rdata_q <= cmp_a_buf_q;
				`TMW_OFS_CMP_B: reg_rdata_q <= cmp_b_buf_q;
				default: reg_rdata_q <= `TMW_RST_BYTE;
			endcase
		end
	end

	// The pin driver also needs its direction bit set by software.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wave_en_a_q <= 1'b0;
			wave_en_b_q <= 1'b0;
		end else begin
			wave_en_a_q <= out_mode_a != 2'b00
				&& !(out_mode_a == 2'b01 && wave_sel != tmw_pkg::TMW_NON_PWM
				&& !ctrl_b_q[`TMW_BIT_WGM_HI]); // R19
			wave_en_b_q <= out_mode_b != 2'b00; // R01 R02
		end
	end

	// ----------------------------------------------------------------
	// Waveform units
	// ----------------------------------------------------------------
	tmw_wave_unit u_wave_a (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wave_sel(wave_sel),
		.out_mode(out_mode_a),
		.toggle_ok(ctrl_b_q[`TMW_BIT_WGM_HI]),
		.match(match_a),
		.force_match(force_a_q),
		.at_top(at_top),
		.at_bottom(at_bottom),
		.cmp_is_top(cmp_a_q == top_val),
		.counting_down(down_q),
		.tick(tick),
		.wave_q(wave_out_a)
	);

	tmw_wave_unit u_wave_b (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wave_sel(wave_sel),
		.out_mode(out_mode_b),
		.toggle_ok(1'b0),
		.match(match_b),
		.force_match(force_b_q),
		.at_top(at_top),
		.at_bottom(at_bottom),
		.cmp_is_top(cmp_b_q == top_val),
		.counting_down(down_q),
		.tick(tick),
		.wave_q(wave_out_b)
	);
endmodule

/* design/tmw_wave_unit.sv */
`timescale 1ns/1ns
`include "tmw_defines.svh"
module tmw_wave_unit (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] wave_sel,
	input wire logic [1:0] out_mode,
	input wire logic toggle_ok,
	input wire logic match,
	input wire logic force_match,
	input wire logic at_top,
	input wire logic at_bottom,
	input wire logic cmp_is_top,
	input wire logic counting_down,
	input wire logic tick,
	output logic wave_q
);
	logic wave_d;
	logic pwm_match;

	always_comb begin
		wave_d = wave_q;
		pwm_match = match && !(cmp_is_top && out_mode[1]); // R06
		case (tmw_pkg::tmw_wave_t'(wave_sel))
			tmw_pkg::TMW_NON_PWM: begin
				if (match || force_match) begin // R12
					case (out_mode)
						2'b01: wave_d = ~wave_q; // R03
						2'b10: wave_d = 1'b0; // R03
						2'b11: wave_d = 1'b1; // R03
						default: wave_d = wave_q;
					endcase
				end
			end
			tmw_pkg::TMW_FAST_PWM: begin
				if (out_mode == 2'b01) begin
					if (toggle_ok && match) wave_d = ~wave_q; // R19
				end else if (out_mode[1] && tick) begin
					if (at_bottom || (cmp_is_top && at_top)) wave_d = ~out_mode[0]; // R04 R06
					else if (pwm_match) wave_d = out_mode[0]; // R04
				end
			end
			tmw_pkg::TMW_PHASE_PWM: begin
				if (out_mode == 2'b01) begin
					if (toggle_ok && match) wave_d = ~wave_q; // R19
				end else if (out_mode[1] && tick) begin
					if (cmp_is_top && at_top) wave_d = out_mode[0]; // R06
					else if (pwm_match) wave_d = counting_down ^ out_mode[0]; // R05
				end
			end
			default: wave_d = wave_q;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wave_q <= 1'b0;
		end else begin
			wave_q <= wave_d;
		end
	end
endmodule

/* include/tmw_defines.svh */
`ifndef TMW_DEFINES_SVH
`define TMW_DEFINES_SVH
// Behaviour
// R01 - Nonzero channel B mode connects pin output.
// R02 - Software sets pin direction to output.
// R03 - Non-PWM: 01 toggle, 10 clear, 11 set.
// R04 - Fast PWM: 10 non-inverting, 11 inverting, 01 reserved.
// R05 - Phase-correct: 10/11 up/down match actions.
// R06 - Compare equals TOP: action moves to TOP.
// R07 - Three-bit waveform mode from two registers.
// R08 - Mode encoding selects sequence and TOP source.
// R09 - Compare update point and overflow point per mode.
// R10 - Force strobes honoured only in non-PWM modes.
// R11 - Software writes zero force bits in PWM.
// R12 - Force strobe applies match using current mode.
// R13 - Forced match sets no flag, no clear.
// R14 - Force bits always read as zero.
// R15 - Clock select 000 stops, 001 every cycle.
// R16 - 010-101 prescaled; 110/111 external falling/rising.
// R17 - External edges count even when pin output.
// R18 - Counter write suppresses next compare match.
// R19 - Channel A mode 01 toggles only with top bit.
// R20 - Ticks advance counter; phase-correct counts up/down.
// R21 - Reserved modes 4 and 6 act as normal.
`define TMW_OFS_CTRL_A 8'h44
`define TMW_OFS_CTRL_B 8'h45
`define TMW_OFS_COUNT 8'h46
`define TMW_OFS_CMP_A 8'h47
`define TMW_OFS_CMP_B 8'h48
`define TMW_RST_BYTE 8'h00
`define TMW_MAX 8'hff
`define TMW_BOTTOM 8'h00
`define TMW_CTRL_A_MASK 8'hf3
`define TMW_CTRL_B_MASK 8'h0f
`define TMW_BIT_FORCE_A 7
`define TMW_BIT_FORCE_B 6
`define TMW_BIT_WGM_HI 3
`define TMW_DIV_8 10'd7
`define TMW_DIV_64 10'd63
`define TMW_DIV_256 10'd255
`define TMW_DIV_1024 10'd1023
`endif

/* include/tmw_pkg.sv */
package tmw_pkg;
	typedef enum logic [1:0] {
		TMW_NON_PWM,
		TMW_FAST_PWM,
		TMW_PHASE_PWM
	} tmw_wave_t;
	typedef enum logic [2:0] {
		TMW_CS_STOP,
		TMW_CS_DIV1,
		TMW_CS_DIV8,
		TMW_CS_DIV64,
		TMW_CS_DIV256,
		TMW_CS_DIV1024,
		TMW_CS_EXT_FALL,
		TMW_CS_EXT_RISE
	} tmw_clk_sel_t;
endpackage

/* verification/timer8_waveform_control_bench.sv */
`timescale 1ns/1ns
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module timer8_waveform_control_bench;
	typedef struct packed {logic [7:0] e; logic [1:0] k;} tmw_note_t;
	logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ext_go = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, last = 8'h00, r;
	logic [7:0] reg_rdata_q;
	logic [3:0] ext_n = 4'h5;
	logic wave_out_a, wave_out_b, wave_en_a_q, wave_en_b_q, pad_b, ext_count_in;
	logic overflow_pulse_q, match_a_pulse_q, match_b_pulse_q, lvl = 1'b0;
	logic rd_pend = 1'b0, pin_req = 1'b0;
	tmw_note_t q[$];
	tmw_note_t nt;
	int mismatches = 0, compares = 0;
	logic [2:0] cs_tab [6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h7, 3'h6};
	int span_tab [6] = '{40, 40, 64, 128, 64, 64};
	logic [7:0] exp_tab [6] = '{8'h28, 8'h00, 8'h08, 8'h02, 8'h05, 8'h05};
	logic [1:0] frc_tab [4] = '{2'h1, 2'h1, 2'h3, 2'h2};
	always #5 ref_clk = ~ref_clk;
	tmw_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.ext_count_in(ext_count_in), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
		.wave_en_a_q(wave_en_a_q), .wave_en_b_q(wave_en_b_q),
		.overflow_pulse_q(overflow_pulse_q), .match_a_pulse_q(match_a_pulse_q),
		.match_b_pulse_q(match_b_pulse_q));
	tmw_host_model host_u (.ref_clk(ref_clk), .ext_go(ext_go), .ext_n(ext_n), .dir_b(1'b1),
		.wave_en_b_q(wave_en_b_q), .wave_out_b(wave_out_b), .pad_b(pad_b),
		.ext_count_in(ext_count_in));
	// ----------------------------------------
	// Bus tasks and result monitor
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk) #1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk) #1 reg_wr = 1'b0;
	endtask
	// Kind 0 compares read data, 2 compares the change since the last read, 3 only records.
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] k);
		@(posedge ref_clk) #1 reg_addr = a;
		reg_rd = 1'b1;
		q.push_back('{e, k});
		@(posedge ref_clk) #1 reg_rd = 1'b0;
	endtask
	task automatic pc(input logic [7:0] e);
		@(posedge ref_clk) #1 pin_req = 1'b1;
		q.push_back('{e, 2'h1});
		@(posedge ref_clk) #1 pin_req = 1'b0;
	endtask
	task automatic final_report();
		if (mismatches == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge ref_clk) rd_pend <= reg_rd;
	always @(negedge ref_clk) begin
		if (rd_pend || pin_req) begin
			nt = q.pop_front();
			case (nt.k)
				2'h0: `CHK("rdata", nt.e, reg_rdata_q)
				2'h1: `CHK("pins", nt.e, {4'h0, wave_out_b, pad_b, wave_en_b_q, wave_en_a_q})
				2'h2: `CHK("count step", nt.e, 8'(reg_rdata_q - last))
				default: ;
			endcase
			if (rd_pend) last = reg_rdata_q;
		end
	end
	initial begin
		#100000;
		mismatches++;
		final_report();
	end
	initial begin
		void'($urandom(32'hd5422ba6));
		repeat (6) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		wr(8'h49, 8'hff);
		wr(8'h43, 8'hff);
		for (int a = 8'h43; a <= 8'h49; a++) rd(8'(a), 8'h00, 2'h0);
		r = 8'($urandom);
		wr(8'h44, r & 8'hfc);
		rd(8'h44, r & 8'hf0, 2'h0);
		r = 8'($urandom);
		wr(8'h45, r & 8'h0f);
		rd(8'h45, r & 8'h0f, 2'h0);
		r = 8'($urandom);
		wr(8'h47, r);
		wr(8'h48, ~r);
		rd(8'h47, r, 2'h0);
		rd(8'h48, ~r, 2'h0);
		wr(8'h44, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(8'h45, {5'h00, cs_tab[i]});
			repeat (4) @(posedge ref_clk);
			rd(8'h46, 8'h00, 2'h3);
			if (cs_tab[i][2:1] == 2'h3) begin
				@(posedge ref_clk) #1 ext_go = 1'b1;
				@(posedge ref_clk) #1 ext_go = 1'b0;
			end
			repeat (span_tab[i] - 2) @(posedge ref_clk);
			rd(8'h46, exp_tab[i], 2'h2);
		end
		wr(8'h45, 8'h00);
		wr(8'h44, 8'h20);
		wr(8'h45, 8'h40);
		for (int m = 0; m < 4; m++) begin
			wr(8'h44, {2'(m), 2'(m), 4'h0});
			repeat (2) @(posedge ref_clk);
			pc({5'h00, m == 0, m != 0, m != 0});
		end
		foreach (frc_tab[i]) begin
			wr(8'h44, {2'h0, frc_tab[i], 4'h0});
			wr(8'h45, 8'h40);
			lvl = (frc_tab[i] == 2'h1) ? ~lvl : frc_tab[i][0];
			repeat (2) @(posedge ref_clk);
			pc({4'h0, lvl, lvl, 2'h2});
		end
		rd(8'h45, 8'h00, 2'h0);
		wr(8'h44, 8'h33);
		wr(8'h45, 8'h40);
		repeat (2) @(posedge ref_clk);
		pc({4'h0, lvl, lvl, 2'h2});
		// Fast PWM from a cleared counter: BOTTOM action first, then the match action.
		wr(8'h44, 8'h00);
		wr(8'h48, 8'h10);
		for (int o = 2; o < 4; o++) begin
			wr(8'h46, 8'h00);
			wr(8'h44, {2'h0, 2'(o), 4'h3});
			wr(8'h45, 8'h01);
			lvl = (o == 2);
			repeat (4) @(posedge ref_clk);
			pc({4'h0, lvl, lvl, 2'h2});
			repeat (20) @(posedge ref_clk);
			pc({4'h0, ~lvl, ~lvl, 2'h2});
			wr(8'h45, 8'h00);
		end
		wr(8'h44, 8'h00);
		wr(8'h45, 8'h01);
		repeat (300) @(posedge ref_clk);
		wr(8'h45, 8'h00);
		repeat (4) @(posedge ref_clk);
		final_report();
	end
endmodule

/* verification/tmw_host_model.sv */
`timescale 1ns/1ns
module tmw_host_model (
	input wire logic ref_clk,
	input wire logic ext_go,
	input wire logic [3:0] ext_n,
	input wire logic dir_b,
	input wire logic wave_en_b_q,
	input wire logic wave_out_b,
	output logic pad_b,
	output logic ext_count_in
);
	// ----------------------------------------
	// Pin and external count source
	// ----------------------------------------
	// The pad has a pull-up, so an undriven pin reads high.
	assign pad_b = (wave_en_b_q && dir_b) ? wave_out_b : 1'b1;
	initial begin
		ext_count_in = 1'b0;
		forever begin
			@(posedge ref_clk iff ext_go);
			repeat (ext_n) begin
				repeat (4) @(posedge ref_clk);
				#1 ext_count_in = 1'b1;
				repeat (4) @(posedge ref_clk);
				#1 ext_count_in = 1'b0;
			end
		end
	end
endmodule

/* verification/tmw_timer_chk.sv */
`timescale 1ns/1ns
module tmw_timer_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic ext_count_in,
	input wire logic wave_out_a,
	input wire logic wave_out_b,
	input wire logic wave_en_a_q,
	input wire logic wave_en_b_q,
	input wire logic overflow_pulse_q,
	input wire logic match_a_pulse_q,
	input wire logic match_b_pulse_q
);
	// ----------------------------------------
	// Shadow of control register A
	// ----------------------------------------
	logic [7:0] shadow_a_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			shadow_a_q <= 8'h00;
		end else if (reg_wr && reg_addr == 8'h44) begin
			shadow_a_q <= reg_wdata;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// The force checks assume the clock was already stopped, so no tick is in flight.
	sequence s_force_b;
		reg_wr && reg_addr == 8'h45 && reg_wdata[6] && reg_wdata[3:0] == 4'h0;
	endsequence
	sequence s_quiet;
		(!match_a_pulse_q && !match_b_pulse_q && !overflow_pulse_q) [*3];
	endsequence
	property p_unmapped;
		reg_rd && (reg_addr < 8'h44 || reg_addr > 8'h48) |=> reg_rdata_q == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctrl_b_read;
		reg_rd && reg_addr == 8'h45 |=> reg_rdata_q[7:4] == 4'h0;
	endproperty
	a_ctrl_b_read: assert property (p_ctrl_b_read) else $error("force bits read one");
	property p_ctrl_a_read;
		reg_rd && reg_addr == 8'h44 |=> reg_rdata_q == (shadow_a_q & 8'hf3);
	endproperty
	a_ctrl_a_read: assert property (p_ctrl_a_read) else $error("control a readback");
	property p_en_b;
		reg_wr && reg_addr == 8'h44 |-> ##2 wave_en_b_q == (shadow_a_q[5:4] != 2'h0);
	endproperty
	a_en_b: assert property (p_en_b) else $error("pin enable b wrong");
	property p_force_toggle;
		s_force_b ##0 shadow_a_q[5:4] == 2'h1 && shadow_a_q[1:0] == 2'h0
			|-> ##2 wave_out_b != $past(wave_out_b, 2);
	endproperty
	a_force_toggle: assert property (p_force_toggle) else $error("force did not toggle");
	property p_force_quiet;
		s_force_b |=> s_quiet;
	endproperty
	a_force_quiet: assert property (p_force_quiet) else $error("force raised event");
	property p_force_pwm;
		s_force_b ##0 shadow_a_q[0] |-> ##2 wave_out_b == $past(wave_out_b, 2);
	endproperty
	a_force_pwm: assert property (p_force_pwm) else $error("force honoured in pwm");
	property p_ovf_gap;
		overflow_pulse_q |=> !overflow_pulse_q [*8];
	endproperty
	a_ovf_gap: assert property (p_ovf_gap) else $error("overflow too close");
endmodule
bind tmw_timer tmw_timer_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.ext_count_in(ext_count_in), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
	.wave_en_a_q(wave_en_a_q), .wave_en_b_q(wave_en_b_q), .overflow_pulse_q(overflow_pulse_q),
	.match_a_pulse_q(match_a_pulse_q), .match_b_pulse_q(match_b_pulse_q));
